// >>> logic/ssbr_pkg.sv
package ssbr_pkg;

    // Register byte offsets on the APB window
    localparam logic [11:0] OFF_MODE    = 12'h000;
    localparam logic [11:0] OFF_CONTROL = 12'h004;
    localparam logic [11:0] OFF_BITRATE = 12'h008;
    localparam logic [11:0] OFF_STATUS  = 12'h00C;
    localparam logic [11:0] OFF_TXDATA  = 12'h010;
    localparam logic [11:0] OFF_RXDATA  = 12'h014;
    localparam logic [11:0] OFF_IRQSTAT = 12'h018;
    localparam logic [11:0] OFF_IRQCLR  = 12'h01C;
    localparam logic [11:0] OFF_IRQEN   = 12'h020;
    localparam logic [11:0] OFF_STANDBY = 12'h024;

    // Values after reset; status and bitrate also after standby
    localparam logic [7:0] RST_STATUS  = 8'h84;
    localparam logic [7:0] RST_BITRATE = 8'hFF;
    localparam logic [7:0] RST_MODE    = 8'h00;

    // Field positions
    localparam int BIT_TX_EMPTY = 7;
    localparam int BIT_RX_FULL  = 6;
    localparam int BIT_ORER     = 5;
    localparam int BIT_FER      = 4;
    localparam int BIT_PAR_ERR  = 3;
    localparam int BIT_TX_END   = 2;
    localparam int BIT_RX_MP    = 1;
    localparam int BIT_TX_MP    = 0;
    localparam int BIT_TX_EN    = 5;
    localparam int BIT_RX_EN    = 4;

    // Oversampling and frame counts
    localparam logic [3:0] TICK_LAST  = 4'hF;
    localparam logic [3:0] TICK_MID   = 4'h8;
    localparam logic [3:0] TXLEN_BASE = 4'hA;
    localparam logic [3:0] RXSTOP_BASE = 4'h9;
    localparam logic [7:0] PRE_BASE   = 8'h04;

    // Mode register layout
    typedef struct packed {
        logic       sync_mode;
        logic       rsvd6;
        logic       parity_en;
        logic       parity_odd;
        logic       rsvd3;
        logic       multiproc;
        logic [1:0] clock_source_select;
    } ssbr_mode_type;

    // Status register layout
    typedef struct packed {
        logic transmit_empty_flag;
        logic receive_full_flag;
        logic overrun_flag;
        logic framing_flag;
        logic parity_error_flag;
        logic transmit_end_flag;
        logic rx_multiproc_bit;
        logic tx_multiproc_bit;
    } ssbr_status_type;

    // Interrupt event layout
    typedef struct packed {
        logic rx_error;
        logic rx_full;
        logic tx_end;
        logic tx_empty;
    } ssbr_irq_type;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b01,
        TX_SHIFT = 2'b10
    } ssbr_tx_state_type;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b01,
        RX_RUN  = 2'b10
    } ssbr_rx_state_type;

endpackage : ssbr_pkg

// >>> logic/ssbr_baud_gen.sv
`timescale 1ns/1ps
module ssbr_baud_gen import ssbr_pkg::*; (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_hold,
    input  wire logic [1:0] i_cks,
    input  wire logic [7:0] i_divider,
    output logic            o_tick
);

    logic [7:0] pre_cnt_ff;
    logic [7:0] div_cnt_ff;
    logic       tick_ff;
    logic [7:0] pre_limit;
    logic       pre_wrap;
    logic       div_wrap;

    // Prescale 4, 16, 64 or 256 clocks per step
    function automatic logic [7:0] pre_last(input logic [1:0] cks);
        return (PRE_BASE << {cks, 1'b0}) - 8'h01;
    endfunction : pre_last

    // One tick is a sixteenth of a bit: 64*4^n*(N+1) clocks per bit
    assign pre_limit = pre_last(i_cks);
    assign pre_wrap  = (pre_cnt_ff == pre_limit);
    assign div_wrap  = pre_wrap && (div_cnt_ff >= i_divider);

    // Prescaler, divider and tick register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_cnt_ff <= 8'h00;
            div_cnt_ff <= 8'h00;
            tick_ff    <= 1'b0;
        end else if (i_hold) begin
            pre_cnt_ff <= 8'h00;
            div_cnt_ff <= 8'h00;
            tick_ff    <= 1'b0;
        end else begin
            pre_cnt_ff <= pre_wrap ? 8'h00 : pre_cnt_ff + 8'h01;
            div_cnt_ff <= div_wrap ? 8'h00 : (pre_wrap ? div_cnt_ff + 8'h01 : div_cnt_ff);
            tick_ff    <= div_wrap;
        end
    end

    assign o_tick = tick_ff;

endmodule : ssbr_baud_gen

// >>> logic/ssbr_top.sv
`timescale 1ns/1ps
// Contract
// - Parity mismatch on received character sets parity flag
// - Parity flag clears: reset, standby, read-then-write-zero
// - Receive enable clear leaves parity flag alone
// - Parity error loads data, receive-full stays clear
// - Parity flag halts receive; sync halts transmit
// - Transmit end flag is read-only
// - Transmit end sets: reset, standby, enable off, drained
// - Transmit end clears on empty-clear or DMA write
// - Received multiproc bit captured, read-only, resets zero
// - Receive enable clear holds received multiproc bit
// - Transmit multiproc bit appended in multiproc format
// - Transmit multiproc bit ignored outside async multiproc
// - Eight-bit divider with clock select sets rate
// - Divider read/write outside standby, loads FF on reset and standby
// - Each channel owns its generator and divider
module ssbr_top import ssbr_pkg::*; (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_rxd,
    output logic             o_txd,
    input  wire logic        i_dma_tx_wr,
    input  wire logic [7:0]  i_dma_tx_data,
    input  wire logic        i_dma_rx_rd,
    output logic      [7:0]  o_rx_data,
    output logic             o_irq
);

    // Registers
    ssbr_mode_type     mode_ff;
    ssbr_status_type   stat_ff;
    ssbr_irq_type      irq_stat_ff;
    ssbr_irq_type      irq_en_ff;
    ssbr_tx_state_type tx_state_ff;
    ssbr_rx_state_type rx_state_ff;
    logic [1:0]  ctrl_ff;
    logic [7:0]  divider_ff;
    logic [7:0]  tdr_ff;
    logic [7:0]  rdr_ff;
    logic [4:0]  armed_ff;
    logic        standby_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;
    logic        irq_ff;
    logic [10:0] tx_shift_ff;
    logic [3:0]  tx_left_ff;
    logic [3:0]  tx_tick_ff;
    logic        rxd_meta_ff;
    logic        rxd_sync_ff;
    logic        rxd_prev_ff;
    logic [9:0]  rx_shift_ff;
    logic [3:0]  rx_idx_ff;
    logic [3:0]  rx_tick_ff;

    // Next values and decode nets
    ssbr_status_type nxt_stat;
    ssbr_irq_type    nxt_irq_stat;
    ssbr_irq_type    irq_ev;
    logic        tick;
    logic        apb_done;
    logic        wr;
    logic        rd;
    logic [7:0]  wd;
    logic        mapped;
    logic [7:0]  rd_byte;
    logic        tx_en;
    logic        rx_en;
    logic        async_mp;
    logic        extra_on;
    logic        err_block;
    logic        stat_wr;
    logic        clr_txe;
    logic        clr_rxf;
    logic        clr_orer;
    logic        clr_fer;
    logic        clr_par;
    logic        tx_load;
    logic        tx_end;
    logic        tx_extra_bit;
    logic        rx_start;
    logic        rx_sample;
    logic        rx_false;
    logic        rx_end;
    logic [3:0]  rx_stop_idx;
    logic [7:0]  rx_data;
    logic        rx_extra_bit;
    logic        per_ev;
    logic        fer_ev;
    logic        orer_ev;
    logic        rdr_load;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction : hit

    // Clear request: write zero to a flag that was read as one
    function automatic logic clr_bit(input logic w, input logic d, input logic armed);
        return w & ~d & armed;
    endfunction : clr_bit

    // This channel's own rate generator; a second channel is a second instance
    ssbr_baud_gen u_baud (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_hold     (standby_ff),
        .i_cks      (mode_ff.clock_source_select),
        .i_divider  (divider_ff),
        .o_tick     (tick)
    );

    // APB access completes on the second access cycle
    assign apb_done = i_psel & i_penable & pready_ff;
    assign wr       = apb_done & i_pwrite;
    assign rd       = apb_done & ~i_pwrite;
    assign wd       = i_pwdata[7:0];

    // Read selection; write-only clear register reads zero
    assign mapped  = hit(i_paddr, OFF_MODE) | hit(i_paddr, OFF_CONTROL)
                   | hit(i_paddr, OFF_BITRATE) | hit(i_paddr, OFF_STATUS)
                   | hit(i_paddr, OFF_TXDATA) | hit(i_paddr, OFF_RXDATA)
                   | hit(i_paddr, OFF_IRQSTAT) | hit(i_paddr, OFF_IRQCLR)
                   | hit(i_paddr, OFF_IRQEN) | hit(i_paddr, OFF_STANDBY);
    assign rd_byte = hit(i_paddr, OFF_MODE)    ? mode_ff :
                     hit(i_paddr, OFF_CONTROL) ? {2'b00, ctrl_ff, 4'h0} :
                     hit(i_paddr, OFF_BITRATE) ? divider_ff :
                     hit(i_paddr, OFF_STATUS)  ? stat_ff :
                     hit(i_paddr, OFF_TXDATA)  ? tdr_ff :
                     hit(i_paddr, OFF_RXDATA)  ? rdr_ff :
                     hit(i_paddr, OFF_IRQSTAT) ? {4'h0, irq_stat_ff} :
                     hit(i_paddr, OFF_IRQEN)   ? {4'h0, irq_en_ff} :
                     hit(i_paddr, OFF_STANDBY) ? {7'h00, standby_ff} : 8'h00;

    // Mode qualifiers
    assign tx_en     = ctrl_ff[1];
    assign rx_en     = ctrl_ff[0];
    assign async_mp  = mode_ff.multiproc & ~mode_ff.sync_mode;
    assign extra_on  = async_mp | mode_ff.parity_en;
    assign err_block = stat_ff.overrun_flag | stat_ff.framing_flag
                     | stat_ff.parity_error_flag;

    // Status clears by software
    assign stat_wr  = wr & hit(i_paddr, OFF_STATUS);
    assign clr_txe  = clr_bit(stat_wr, wd[BIT_TX_EMPTY], armed_ff[4]);
    assign clr_rxf  = clr_bit(stat_wr, wd[BIT_RX_FULL], armed_ff[3]);
    assign clr_orer = clr_bit(stat_wr, wd[BIT_ORER], armed_ff[2]);
    assign clr_fer  = clr_bit(stat_wr, wd[BIT_FER], armed_ff[1]);
    assign clr_par  = clr_bit(stat_wr, wd[BIT_PAR_ERR], armed_ff[0]);

    // Transmit: load on a tick so the start bit is a whole bit time
    assign tx_load = (tx_state_ff == TX_IDLE) & tx_en & ~standby_ff & tick
                   & ~stat_ff.transmit_empty_flag
                   & ~(mode_ff.sync_mode & err_block);
    // Multiproc bit only in async multiproc format, else parity
    assign tx_extra_bit = async_mp ? stat_ff.tx_multiproc_bit
                                   : (^tdr_ff) ^ mode_ff.parity_odd;
    assign tx_end = (tx_state_ff == TX_SHIFT) & tick
                  & (tx_tick_ff == TICK_LAST) & (tx_left_ff == 4'h1);

    // Receive: start bit seen only while no error flag is set
    assign rx_start  = (rx_state_ff == RX_IDLE) & rx_en & ~standby_ff & ~err_block
                     & rxd_prev_ff & ~rxd_sync_ff;
    assign rx_sample = (rx_state_ff == RX_RUN) & tick & (rx_tick_ff == TICK_LAST);
    assign rx_stop_idx = RXSTOP_BASE + {3'b000, extra_on};
    assign rx_false  = rx_sample & (rx_idx_ff == 4'h0) & rxd_sync_ff;
    assign rx_end    = rx_sample & (rx_idx_ff == rx_stop_idx);
    assign rx_data   = extra_on ? rx_shift_ff[8:1] : rx_shift_ff[9:2];
    assign rx_extra_bit = rx_shift_ff[9];

    // Receive error events and data move
    assign per_ev   = rx_end & mode_ff.parity_en & ~async_mp
                    & ((^{rx_data, rx_extra_bit}) != mode_ff.parity_odd);
    assign fer_ev   = rx_end & ~rxd_sync_ff;
    assign orer_ev  = rx_end & stat_ff.receive_full_flag;
    assign rdr_load = rx_end & ~orer_ev;

    // Status next values; a setting event wins over a clear
    always_comb begin
        nxt_stat = stat_ff;
        if (tx_load)
            nxt_stat.transmit_empty_flag = 1'b1;
        else if (clr_txe | i_dma_tx_wr)
            nxt_stat.transmit_empty_flag = 1'b0;
        if (rdr_load & ~per_ev & ~fer_ev)
            nxt_stat.receive_full_flag = 1'b1;
        else if (clr_rxf | i_dma_rx_rd)
            nxt_stat.receive_full_flag = 1'b0;
        if (orer_ev)
            nxt_stat.overrun_flag = 1'b1;
        else if (clr_orer)
            nxt_stat.overrun_flag = 1'b0;
        if (fer_ev)
            nxt_stat.framing_flag = 1'b1;
        else if (clr_fer)
            nxt_stat.framing_flag = 1'b0;
        // Receive enable plays no part here, so the flag holds
        if (per_ev)
            nxt_stat.parity_error_flag = 1'b1;
        else if (clr_par)
            nxt_stat.parity_error_flag = 1'b0;
        // Software writes never reach this flag directly
        if (tx_end & stat_ff.transmit_empty_flag)
            nxt_stat.transmit_end_flag = 1'b1;
        else if (clr_txe | i_dma_tx_wr)
            nxt_stat.transmit_end_flag = 1'b0;
        if (rx_end & async_mp)
            nxt_stat.rx_multiproc_bit = rx_extra_bit;
        if (stat_wr)
            nxt_stat.tx_multiproc_bit = wd[BIT_TX_MP];
        // Transmit enable off forces empty and end
        if (~tx_en) begin
            nxt_stat.transmit_empty_flag = 1'b1;
            nxt_stat.transmit_end_flag   = 1'b1;
        end
        if (standby_ff)
            nxt_stat = RST_STATUS;
    end

    // Interrupt events, sticky with set over clear
    assign irq_ev = '{rx_error: per_ev | fer_ev | orer_ev,
                      rx_full:  rdr_load & ~per_ev & ~fer_ev,
                      tx_end:   tx_end & stat_ff.transmit_empty_flag,
                      tx_empty: tx_load};
    assign nxt_irq_stat = irq_ev
                        | (irq_stat_ff & ~((wr & hit(i_paddr, OFF_IRQCLR)) ? wd[3:0] : 4'h0));

    // APB handshake and read data
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= i_psel & i_penable & ~pready_ff;
            pslverr_ff <= i_psel & i_penable & ~pready_ff & ~mapped;
            prdata_ff  <= (i_psel & i_penable & ~pready_ff & ~i_pwrite)
                        ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Software-written control registers
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_ff    <= RST_MODE;
            ctrl_ff    <= 2'b00;
            divider_ff <= RST_BITRATE;
            tdr_ff     <= 8'h00;
            irq_en_ff  <= 4'h0;
            standby_ff <= 1'b0;
        end else begin
            if (wr & hit(i_paddr, OFF_MODE))
                mode_ff <= wd;
            if (wr & hit(i_paddr, OFF_CONTROL))
                ctrl_ff <= {wd[BIT_TX_EN], wd[BIT_RX_EN]};
            if (standby_ff)
                divider_ff <= RST_BITRATE;
            else if (wr & hit(i_paddr, OFF_BITRATE))
                divider_ff <= wd;
            if (i_dma_tx_wr)
                tdr_ff <= i_dma_tx_data;
            else if (wr & hit(i_paddr, OFF_TXDATA))
                tdr_ff <= wd;
            if (wr & hit(i_paddr, OFF_IRQEN))
                irq_en_ff <= wd[3:0];
            if (wr & hit(i_paddr, OFF_STANDBY))
                standby_ff <= wd[0];
        end
    end

    // Status, read arming and interrupt state
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            stat_ff     <= RST_STATUS;
            armed_ff    <= 5'h00;
            irq_stat_ff <= 4'h0;
            irq_ff      <= 1'b0;
        end else begin
            stat_ff     <= nxt_stat;
            irq_stat_ff <= nxt_irq_stat;
            irq_ff      <= |(nxt_irq_stat & irq_en_ff);
            if (stat_wr | standby_ff)
                armed_ff <= 5'h00;
            else if (rd & hit(i_paddr, OFF_STATUS))
                armed_ff <= stat_ff[7:3];
        end
    end

    // Transmit shifter: start, data, optional extra bit, stop
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_state_ff <= TX_IDLE;
            tx_shift_ff <= 11'h7FF;
            tx_left_ff  <= 4'h0;
            tx_tick_ff  <= 4'h0;
        end else if (~tx_en | standby_ff) begin
            tx_state_ff <= TX_IDLE;
            tx_shift_ff <= 11'h7FF;
            tx_left_ff  <= 4'h0;
            tx_tick_ff  <= 4'h0;
        end else begin
            case (tx_state_ff)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_state_ff <= TX_SHIFT;
                        tx_shift_ff <= extra_on ? {1'b1, tx_extra_bit, tdr_ff, 1'b0}
                                                : {2'b11, tdr_ff, 1'b0};
                        tx_left_ff  <= TXLEN_BASE + {3'b000, extra_on};
                        tx_tick_ff  <= 4'h0;
                    end
                end
                TX_SHIFT: begin
                    if (tick) begin
                        tx_tick_ff <= tx_tick_ff + 4'h1;
                        if (tx_tick_ff == TICK_LAST) begin
                            tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                            tx_left_ff  <= tx_left_ff - 4'h1;
                            if (tx_left_ff == 4'h1)
                                tx_state_ff <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state_ff <= TX_IDLE;
                end
            endcase
        end
    end

    // Two-flop synchroniser on the receive pin, then edge history
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rxd_meta_ff <= 1'b1;
            rxd_sync_ff <= 1'b1;
            rxd_prev_ff <= 1'b1;
        end else begin
            rxd_meta_ff <= i_rxd;
            rxd_sync_ff <= rxd_meta_ff;
            rxd_prev_ff <= rxd_sync_ff;
        end
    end

    // Receive sampler: mid-bit samples every sixteen ticks
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_state_ff <= RX_IDLE;
            rx_shift_ff <= 10'h000;
            rx_idx_ff   <= 4'h0;
            rx_tick_ff  <= 4'h0;
        end else if (~rx_en | standby_ff) begin
            rx_state_ff <= RX_IDLE;
            rx_idx_ff   <= 4'h0;
        end else begin
            case (rx_state_ff)
                RX_IDLE: begin
                    if (rx_start) begin
                        rx_state_ff <= RX_RUN;
                        rx_idx_ff   <= 4'h0;
                        rx_tick_ff  <= TICK_MID;
                    end
                end
                RX_RUN: begin
                    if (tick)
                        rx_tick_ff <= rx_tick_ff + 4'h1;
                    if (rx_false | rx_end) begin
                        rx_state_ff <= RX_IDLE;
                    end else if (rx_sample) begin
                        rx_idx_ff <= rx_idx_ff + 4'h1;
                        if (rx_idx_ff != 4'h0)
                            rx_shift_ff <= {rxd_sync_ff, rx_shift_ff[9:1]};
                    end
                end
                default: begin
                    rx_state_ff <= RX_IDLE;
                end
            endcase
        end
    end

    // Receive data register; loaded even when parity fails
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst)
            rdr_ff <= 8'h00;
        else if (rdr_load)
            rdr_ff <= rx_data;
    end

    assign o_prdata  = prdata_ff;
    assign o_pready  = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_txd     = tx_shift_ff[0];
    assign o_rx_data = rdr_ff;
    assign o_irq     = irq_ff;

endmodule : ssbr_top

// >>> dv/ssbr_sva.sv
`timescale 1ns/1ps
module ssbr_sva (
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_txd
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic [15:0] low_cnt_ff;
    // Length of the current low run on the serial output
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) low_cnt_ff <= 16'h0000;
        else low_cnt_ff <= o_txd ? 16'h0000 : low_cnt_ff + 16'h0001;
    end
    // Setup cycle followed by the first access cycle
    sequence s_setup_access;
        i_psel && !i_penable ##1 i_psel && i_penable;
    endsequence
    a_pready_wait: assert property (s_setup_access |=> o_pready)
        else $error("pready late");
    a_pready_pulse: assert property (o_pready |=> !o_pready) else $error("pready held");
    a_pready_cause: assert property (o_pready |-> i_psel && $past(i_penable))
        else $error("pready without access");
    a_slverr_pair: assert property (o_pslverr |-> o_pready) else $error("stray pslverr");
    a_prdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("prdata outside access");
    a_prdata_upper: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_start_hold: assert property ($fell(o_txd) |-> (!o_txd) [*8])
        else $error("start bit short");
    a_bit_length: assert property ($rose(o_txd) |-> low_cnt_ff[5:0] == 6'h00)
        else $error("low run not whole bits");
endmodule : ssbr_sva

// >>> dv/ssbr_peer.sv
`timescale 1ns/1ps
module ssbr_peer #(
    parameter int BIT_CLKS = 64
) (
    input  wire logic i_core_clk,
    input  wire logic i_txd,
    output logic      o_rxd
);
    // Line idles at mark level
    initial o_rxd = 1'b1;
    // Start, eight data bits LSB first, extra bit, stop
    task automatic send(input logic [7:0] d, input logic x);
        logic [10:0] f;
        f = {1'b1, x, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            o_rxd <= f[i];
            repeat (BIT_CLKS) @(posedge i_core_clk);
        end
    endtask : send
    // Samples the data bits and extra bit at their middles after the start edge
    task automatic recv(output logic [7:0] d, output logic x);
        logic [8:0] sh;
        sh = 9'h000;
        @(negedge i_txd);
        repeat (BIT_CLKS / 2) @(posedge i_core_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CLKS) @(posedge i_core_clk);
            sh = {i_txd, sh[8:1]};
        end
        {x, d} = sh;
    endtask : recv
endmodule : ssbr_peer

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb import ssbr_pkg::*;;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, dma_wr = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [7:0]  dma_d = 8'h00, rx_d, tx_d;
    logic        slverr, last_err, pready, txd, rxd, irq, x;
    int          errors = 0, checks_done = 0;
    // Core clock
    always #5 clk = ~clk;
    ssbr_top u_dut (.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(slverr), .i_rxd(rxd), .o_txd(txd),
        .i_dma_tx_wr(dma_wr), .i_dma_tx_data(dma_d), .i_dma_rx_rd(1'b0),
        .o_rx_data(rx_d), .o_irq(irq));
    ssbr_peer u_peer (.i_core_clk(clk), .i_txd(txd), .o_rxd(rxd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) errors++;
        rdat = prdata;
        last_err = slverr;
        {psel, pen} <= 2'b00;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat & {24'h0, m}, {24'h0, e});
    endtask : rd
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        stop_test();
    end
    // Test sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_STATUS, 8'hFF, RST_STATUS);
        rd(OFF_BITRATE, 8'hFF, 8'hFF);
        wr(OFF_BITRATE, 8'h00);
        rd(OFF_BITRATE, 8'hFF, 8'h00);
        wr(OFF_STATUS, 8'h80);
        rd(OFF_STATUS, 8'h04, 8'h04);
        apb(1'b0, 12'h040, 32'h0);
        chk(rdat, 32'h0);
        chk(last_err, 1'b1);
        // Even parity, bad then good frame
        wr(OFF_MODE, 8'h20);
        wr(OFF_CONTROL, 8'h30);
        u_peer.send(8'hA5, 1'b1);
        repeat (4) @(posedge clk);
        rd(OFF_STATUS, 8'h48, 8'h08);
        chk(rx_d, 8'hA5);
        u_peer.send(8'h3C, 1'b0);
        repeat (4) @(posedge clk);
        chk(rx_d, 8'hA5);
        rd(OFF_STATUS, 8'h48, 8'h08);
        wr(OFF_CONTROL, 8'h20);
        rd(OFF_STATUS, 8'h08, 8'h08);
        wr(OFF_STATUS, 8'hF6);
        rd(OFF_STATUS, 8'h08, 8'h00);
        // Multiprocessor receive
        wr(OFF_MODE, 8'h04);
        wr(OFF_CONTROL, 8'h30);
        u_peer.send(8'h11, 1'b1);
        repeat (4) @(posedge clk);
        rd(OFF_STATUS, 8'h42, 8'h42);
        chk(rx_d, 8'h11);
        wr(OFF_CONTROL, 8'h20);
        wr(OFF_STATUS, 8'hFD);
        rd(OFF_STATUS, 8'h03, 8'h03);
        // Transmit with multiprocessor bit set
        wr(OFF_TXDATA, 8'h5A);
        rd(OFF_STATUS, 8'h80, 8'h80);
        fork
            wr(OFF_STATUS, 8'h7F);
            u_peer.recv(tx_d, x);
        join
        chk(tx_d, 8'h5A);
        chk(x, 1'b1);
        repeat (100) @(posedge clk);
        rd(OFF_STATUS, 8'h04, 8'h04);
        rd(OFF_IRQSTAT, 8'h02, 8'h02);
        chk(irq, 1'b0);
        wr(OFF_IRQEN, 8'h02);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        wr(OFF_IRQCLR, 8'h02);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        // DMA load with multiprocessor bit clear
        wr(OFF_STATUS, 8'hFE);
        fork
            begin
                @(posedge clk);
                {dma_wr, dma_d} <= {1'b1, 8'hC3};
                @(posedge clk);
                dma_wr <= 1'b0;
                rd(OFF_STATUS, 8'h04, 8'h00);
            end
            u_peer.recv(tx_d, x);
        join
        chk(tx_d, 8'hC3);
        chk(x, 1'b0);
        repeat (100) @(posedge clk);
        wr(OFF_STANDBY, 8'h01);
        wr(OFF_STANDBY, 8'h00);
        rd(OFF_BITRATE, 8'hFF, 8'hFF);
        rd(OFF_STATUS, 8'h0F, 8'h04);
        stop_test();
    end
endmodule : tb
bind ssbr_top ssbr_sva u_sva (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_txd(o_txd));
